/* File: hw/wait_bridge_consts.vh */
/*
 Constants for the peripheral bus wait insertion bridge.
 Assumes a single 250 MHz CPU clock and classic Wishbone on both sides.
*/
// Functional notes
// RL1: A CPU access to a wait-generating register is held (retried) until valid data passes, and the CPU does not move on meanwhile.
// RL2: An instruction with peripheral waits takes its normal cycles plus exactly the inserted wait cycles.
// RL3: A write to watchdog_mode_reg stalls the CPU for exactly three CPU clocks.
// RL4: A read of rx_error_status_reg stalls the CPU for exactly one CPU clock.
// RL5: Writes to the four A/D configuration registers insert 2 to 5 waits with the speed bit set, 2 to 9 with it clear.
// RL6: Reads of adc_result_reg insert 1 to 5 waits with the speed bit set, 1 to 9 with it clear.
// RL7: The maximum A/D wait is twice the CPU-to-macro clock ratio plus one, with the fraction dropped below the CPU low time and rounded up otherwise.
// RL8: The A/D macro clock is the high speed system clock over 2 when speed bit 5 is set and over 4 when clear.
// RL9: If the computed A/D wait count is exactly one, a register write gets no wait.
// RL10: Where an A/D write would need no wait, an adc_result_reg read still takes one wait.
// RL11: All inserted waits are counted in CPU clock periods.
// RL12: Accesses to other peripheral registers complete with no inserted wait.
`ifndef WAIT_BRIDGE_CONSTS_VH
`define WAIT_BRIDGE_CONSTS_VH

// Peripheral register byte offsets (word aligned)
`define OFS_WATCHDOG_MODE   8'h00
`define OFS_RX_ERROR_STATUS 8'h04
`define OFS_ADC_MODE        8'h08
`define OFS_ADC_CHANNEL     8'h0c
`define OFS_PF_COMPARE_MODE 8'h10
`define OFS_PF_THRESHOLD    8'h14
`define OFS_ADC_RESULT      8'h18
// Bridge's own control/status registers
`define OFS_CLK_CONFIG      8'h40
`define OFS_WAIT_STATUS     8'h44

`define ADC_SPEED_BIT       5
`define WATCHDOG_WAITS      4'h3
`define RX_STATUS_WAITS     4'h1
`define ADC_RESULT_MIN_WAIT 4'h1

// CPU clock divider exponent (fcpu = fx / 2**n), field of clk_config
`define CPU_DIV_LSB         0
`define CPU_DIV_MSB         2
// CPU clock low time and fx clock period, both in ns
`define CPU_LOW_NS          50
`define FX_PERIOD_NS        100
`define CLK_CONFIG_RESET    32'h0000_0000
`define ADC_MODE_RESET      8'h00

`endif

/* File: hw/wait_bridge.v */
/*
 Wishbone slave that models the CPU-side access to low-speed peripheral
 registers and stretches ack by the documented number of CPU wait clocks.
 Assumes a classic single-cycle Wishbone master on the same clock.
*/
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "wait_bridge_consts.vh"

module wait_bridge (
   input  wire        clk,      // 250 MHz CPU clock
   input  wire        rst_n,    // Asynchronous reset, active low
   input  wire        cyc_i,    // Wishbone cycle
   input  wire        stb_i,    // Wishbone strobe
   input  wire        we_i,     // Write enable
   input  wire [7:0]  adr_i,    // Byte address
   input  wire [3:0]  sel_i,    // Byte lanes
   input  wire [31:0] dat_i,    // Write data
   output reg  [31:0] dat_o,    // Read data
   output wire        ack_o,    // Acknowledge
   output wire [3:0]  wait_cnt  // Waits inserted on last access
);

   localparam [1:0] S_IDLE = 2'd0;
   localparam [1:0] S_WAIT = 2'd1;
   localparam [1:0] S_ACK  = 2'd2;
   localparam [1:0] S_DONE = 2'd3;

   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [3:0]  cnt_q;
   reg  [3:0]  last_wait_q;
   reg  [31:0] clk_config_q;
   reg  [7:0]  regs_q [0:6];
   wire [2:0]  cpu_div;
   wire        speed;
   reg  [3:0]  adc_max;
   reg  [3:0]  adc_wr_wait;
   reg  [3:0]  adc_rd_wait;
   reg  [3:0]  need;
   wire        req;
   wire        is_periph;
   wire [2:0]  idx;

   assign req       = cyc_i & stb_i;
   assign cpu_div   = clk_config_q[`CPU_DIV_MSB:`CPU_DIV_LSB];
   assign speed     = regs_q[2][`ADC_SPEED_BIT];
   assign idx       = adr_i[4:2];
   assign is_periph = (adr_i[7:5] == 3'h0) && (idx != 3'h7);
   assign ack_o     = (state_q == S_ACK);
   assign wait_cnt  = last_wait_q;

   // Max A/D waits = 2*fcpu/adc_macro_clock_freq + 1, in CPU clocks
   always @* begin
      adc_max = 4'h0;
      case ({speed, cpu_div})                                   // RL7 RL8
         4'b1_000: adc_max = 4'h5; // fcpu/adc_macro_clock_freq = 2
         4'b1_001: adc_max = 4'h3; // ratio 1
         4'b1_010: adc_max = 4'h2; // ratio 1/2, fraction kept
         4'b1_011: adc_max = 4'h1; // ratio 1/4, fraction below low time
         4'b1_100: adc_max = 4'h1;
         4'b0_000: adc_max = 4'h9; // ratio 4
         4'b0_001: adc_max = 4'h5;
         4'b0_010: adc_max = 4'h3;
         4'b0_011: adc_max = 4'h2;
         4'b0_100: adc_max = 4'h1;
         default:  adc_max = 4'h1;
      endcase
   end

   always @* begin
      adc_wr_wait = (adc_max == 4'h1) ? 4'h0 : adc_max;          // RL9 RL5
      adc_rd_wait = (adc_wr_wait == 4'h0) ? `ADC_RESULT_MIN_WAIT
                                          : adc_wr_wait;         // RL10 RL6
   end

   // Wait count per register and direction, in CPU clocks
   always @* begin
      need = 4'h0;                                               // RL12
      case (adr_i)
         `OFS_WATCHDOG_MODE:   need = we_i ? `WATCHDOG_WAITS : 4'h0; // RL3
         `OFS_RX_ERROR_STATUS: need = we_i ? 4'h0 : `RX_STATUS_WAITS; // RL4
         `OFS_ADC_MODE,
         `OFS_ADC_CHANNEL,
         `OFS_PF_COMPARE_MODE,
         `OFS_PF_THRESHOLD:    need = we_i ? adc_wr_wait : 4'h0;  // RL5
         `OFS_ADC_RESULT:      need = we_i ? 4'h0 : adc_rd_wait;  // RL6
         default:              need = 4'h0;
      endcase
   end

   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (req)
               state_d = (need == 4'h0) ? S_ACK : S_WAIT;
         end
         S_WAIT: begin
            if (cnt_q == 4'h1)                                   // RL1
               state_d = S_ACK;
         end
         S_ACK:   state_d = S_DONE;
         S_DONE:  state_d = req ? S_DONE : S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= S_IDLE;
         cnt_q       <= 4'h0;
         last_wait_q <= 4'h0;
      end else begin
         state_q <= state_d;
         if (state_q == S_IDLE && req) begin
            cnt_q       <= need;                                 // RL2
            last_wait_q <= need;
         end else if (state_q == S_WAIT) begin
            cnt_q <= cnt_q - 4'h1;                               // RL11
         end
      end
   end

   // Register storage; writes land with the ack
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_reg
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n)
               regs_q[g] <= `ADC_MODE_RESET;
            else if (ack_o && we_i && sel_i[0] && is_periph && idx == g)
               regs_q[g] <= dat_i[7:0];
         end
      end
   endgenerate

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         clk_config_q <= `CLK_CONFIG_RESET;
      else if (ack_o && we_i && adr_i == `OFS_CLK_CONFIG && sel_i[0])
         clk_config_q <= {29'h0, dat_i[2:0]};
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dat_o <= 32'h0000_0000;
      end else if (state_d == S_ACK && state_q != S_ACK && !we_i) begin
         if (is_periph)
            dat_o <= {24'h0, regs_q[idx]};
         else if (adr_i == `OFS_CLK_CONFIG)
            dat_o <= clk_config_q;
         else if (adr_i == `OFS_WAIT_STATUS)
            dat_o <= {28'h0, last_wait_q};
         else
            dat_o <= 32'h0000_0000;
      end
   end

endmodule

/* File: verification/wait_bridge_chk.sv */
/* Stall checker for wait_bridge. Assumes stb_i follows cyc_i, as the bench drives it. */
`timescale 1ns/1ps
module wait_bridge_chk (
   input logic       clk,      // Clock
   input logic       rst_n,    // Reset
   input logic       cyc_i,    // Cycle
   input logic       we_i,     // Write
   input logic [7:0] adr_i,    // Address
   input logic       ack_o,    // Ack
   input logic [3:0] wait_cnt  // Waits
);
   logic [3:0] cnt_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 4'h0;
      else cnt_q <= (cyc_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_wdt_wait: assert property ($rose(cyc_i) && we_i && adr_i == 8'h00 |-> !ack_o[*4] ##1 ack_o)
      else $error("wdt");
   a_rx_wait: assert property ($rose(cyc_i) && !we_i && adr_i == 8'h04 |-> !ack_o[*2] ##1 ack_o)
      else $error("rx");
   a_plain_ack: assert property ($rose(cyc_i) && adr_i > 8'h18 |=> ack_o)
      else $error("plain");
   a_adc_result_reg_wait: assert property ($rose(cyc_i) && !we_i && adr_i == 8'h18 |-> !ack_o[*2] ##[1:9] ack_o)
      else $error("adc_result_reg");
   a_adcw_wait: assert property ($rose(cyc_i) && we_i && adr_i inside {[8'h08:8'h14]} |-> ##[1:10] ack_o)
      else $error("adcw");
   a_wait_report: assert property (ack_o |-> ##2 wait_cnt == $past(cnt_q, 2) - 4'h1)
      else $error("count");
   a_ack_pulse: assert property (ack_o |-> cyc_i ##1 !ack_o) else $error("ack");
   a_wait_cap: assert property (cnt_q <= 4'ha) else $error("cap");
   c_wdt: cover property ($rose(cyc_i) && we_i && adr_i == 8'h00);
   c_adc_result_reg: cover property (ack_o && adr_i == 8'h18);
   c_long: cover property (cnt_q == 4'ha);
endmodule
bind wait_bridge wait_bridge_chk u_chk (.clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .we_i(we_i),
   .adr_i(adr_i), .ack_o(ack_o), .wait_cnt(wait_cnt));

/* File: verification/cpu_master.sv */
/* CPU-side bus master model. Assumes a Wishbone slave on the same clock. */
`timescale 1ns/1ps
module cpu_master (
   input  logic        clk,          // Clock
   input  logic        ack,          // Ack
   input  logic [31:0] rdat,         // Read data
   output logic        cyc = 1'b0,   // Cycle and strobe
   output logic        we = 1'b0,    // Write
   output logic [7:0]  adr = 8'h00,  // Address
   output logic [31:0] wdat = 32'h0  // Write data
);
   // Returns edges from launch to the ack edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output int n);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      for (n = 1; ack !== 1'b1 && n < 40; n++) @(posedge clk);
      q = rdat;
      cyc <= 1'b0;
      wdat <= ~d;
   endtask
endmodule

/* File: verification/wait_bridge_tb_top.sv */
/* Top bench for wait_bridge: stall counts per register. Assumes cpu_master. */
`timescale 1ns/1ps
module wait_bridge_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc, we, ack;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [3:0]  wc;
   int          err_count = 0;
   int          comparisons = 0;
   int          n, ps, cycles = 0;
   int          tbl [2][5] = '{'{9, 5, 3, 2, 0}, '{5, 3, 2, 0, 0}};
   initial forever #2 clk = ~clk;
   cpu_master cpu (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .we(we), .adr(adr), .wdat(wdat));
   wait_bridge dut (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
                    .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .wait_cnt(wc));
   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input int x);
      cpu.xfer(w, a, d, q, n);
      chk(n - 2, x);
      chk({33'h0, wc}, x);
   endtask
   task automatic finish_test;
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      ps = 0;
      repeat (3) @(posedge clk);
      chk({ack, wc, rdat}, 37'h0);
      rst_n <= 1'b1;
      acc(1'b1, 8'h00, 32'h5a, 3);
      acc(1'b0, 8'h04, 32'h0, 1);
      acc(1'b0, 8'h80, 32'h0, 0);
      chk(q, 0);
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 5; k++) begin
            acc(1'b1, 8'h40, k, 0);
            acc(1'b1, 8'h08, s << 5, tbl[ps][k]);
            ps = s;
            for (int a = 8'h0c; a < 8'h18; a += 4) acc(1'b1, 8'(a), k, tbl[s][k]);
            acc(1'b0, 8'h18, 32'h0, tbl[s][k] ? tbl[s][k] : 1);
            acc(1'b0, 8'h44, 32'h0, 0);
            chk(q, tbl[s][k] ? tbl[s][k] : 1);
            acc(1'b0, 8'h08, 32'h0, 0);
            chk(q, s << 5);
         end
      end
      finish_test();
   end
endmodule
